// ### design/socd_pkg.sv
/*
 Shared constants for the host-side serial opcode controller: opcode
 encodings, field layouts and master-clock timing counts.
 Assumes a 125 MHz controller clock and a device master clock given in ns.
*/
package socd_pkg;
    localparam int REF_CLK_PERIOD_NS = 8;
    localparam int DEV_CLK_PERIOD_NS = 500;
    localparam int DEC_GAP_TCLK = 4;
    localparam int RESET_TCLK = 18;
    localparam int GAP_CYC = (DEC_GAP_TCLK * DEV_CLK_PERIOD_NS + REF_CLK_PERIOD_NS - 1)
        / REF_CLK_PERIOD_NS;
    localparam int RESET_CYC = (RESET_TCLK * DEV_CLK_PERIOD_NS + REF_CLK_PERIOD_NS - 1)
        / REF_CLK_PERIOD_NS;
    localparam int SCLK_HALF = 4;

    localparam logic [7:0] OP_WAKEUP = 8'h02;
    localparam logic [7:0] OP_STANDBY = 8'h04;
    localparam logic [7:0] OP_RESET = 8'h06;
    localparam logic [7:0] OP_START = 8'h08;
    localparam logic [7:0] OP_STOP = 8'h0A;
    localparam logic [7:0] OP_CONT_READ = 8'h10;
    localparam logic [7:0] OP_STOP_CONT = 8'h11;
    localparam logic [7:0] OP_SINGLE_READ = 8'h12;
    localparam logic [2:0] PFX_REG_READ = 3'h1;
    localparam logic [2:0] PFX_REG_WRITE = 3'h2;
    localparam logic [2:0] PFX_COUNT = 3'h0;

    localparam logic [3:0] CMD_WAKEUP = 4'h0;
    localparam logic [3:0] CMD_STANDBY = 4'h1;
    localparam logic [3:0] CMD_RESET = 4'h2;
    localparam logic [3:0] CMD_START = 4'h3;
    localparam logic [3:0] CMD_STOP = 4'h4;
    localparam logic [3:0] CMD_CONT_READ = 4'h5;
    localparam logic [3:0] CMD_STOP_CONT = 4'h6;
    localparam logic [3:0] CMD_SINGLE_READ = 4'h7;
    localparam logic [3:0] CMD_REG_READ = 4'h8;
    localparam logic [3:0] CMD_REG_WRITE = 4'h9;
endpackage

// ### design/socd_host.sv
/*
 Host controller that drives the converter's serial port: sends opcodes,
 register read and write commands, and reads conversion data.
 Assumes the device launches read data on the rising link clock edge (link
 clock made here by dividing ref_clk) and a result_ready_n pin, sampled through three flops.
*/
`timescale 1ns/10ps
module socd_host
    import socd_pkg::*;
#(
    parameter int DATA_BYTES = 27,
    parameter int GAP_CYCLES = GAP_CYC,
    parameter int RESET_CYCLES = RESET_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [3:0] cmd_code,
    input wire logic [4:0] cmd_addr,
    input wire logic [4:0] cmd_count,
    output logic wr_data_ready,
    input wire logic [7:0] wr_data,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic cmd_refused,
    output logic standby,
    output logic cont_read,
    output logic running,
    output logic ser_clk,
    output logic ser_sel_n,
    output logic ser_mosi,
    input wire logic ser_miso,
    output logic start_pin,
    input wire logic result_ready_n
);
    typedef enum logic [5:0] {
        SOCD_IDLE = 6'b00_0001,
        SOCD_SHIFT = 6'b00_0010,
        SOCD_GAP = 6'b00_0100,
        SOCD_NEXT = 6'b00_1000,
        SOCD_HOLD = 6'b01_0000,
        SOCD_WAITRDY = 6'b10_0000
    } socd_state_t;

    localparam int CW = 16;
    localparam logic [CW-1:0] GAP_W = CW'(GAP_CYCLES);
    localparam logic [CW-1:0] RST_W = CW'(RESET_CYCLES);
    localparam logic [CW-1:0] HALF_W = CW'(SCLK_HALF);

    logic [2:0] miso_s_q;
    logic [2:0] rdy_s_q;
    socd_state_t st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [CW-1:0] hold_q, hold_d;
    logic [7:0] sh_q, sh_d;
    logic [2:0] bit_q, bit_d;
    logic [9:0] bytes_q, bytes_d;
    logic [9:0] hdr_q, hdr_d;
    logic [3:0] op_q, op_d;
    logic sclk_q, sclk_d;
    logic sel_n_q, sel_n_d;
    logic standby_q, standby_d;
    logic cont_q, cont_d;
    logic run_q, run_d;
    logic rdv_q, rdv_d;
    logic [7:0] rdd_q, rdd_d;
    logic ref_q, ref_d;
    logic legal;
    logic [7:0] first_byte;

    // Miso and ready pin are asynchronous to ref_clk
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            miso_s_q <= 3'h0;
            rdy_s_q <= 3'h7;
        end else if (clk_en) begin
            miso_s_q <= {miso_s_q[1:0], ser_miso};
            rdy_s_q <= {rdy_s_q[1:0], result_ready_n};
        end
    end

    always_comb begin
        legal = 1'b1;
        if (standby_q && cmd_code != CMD_WAKEUP) begin
            legal = 1'b0;
        end
        if (cont_q && cmd_code != CMD_STOP_CONT && cmd_code != CMD_CONT_READ) begin
            legal = 1'b0;
        end
        if (cmd_code > CMD_REG_WRITE) begin
            legal = 1'b0;
        end
        unique case (cmd_code)
            CMD_WAKEUP: first_byte = OP_WAKEUP;
            CMD_STANDBY: first_byte = OP_STANDBY;
            CMD_RESET: first_byte = OP_RESET;
            CMD_START: first_byte = OP_START;
            CMD_STOP: first_byte = OP_STOP;
            CMD_CONT_READ: first_byte = OP_CONT_READ;
            CMD_STOP_CONT: first_byte = OP_STOP_CONT;
            CMD_SINGLE_READ: first_byte = OP_SINGLE_READ;
            CMD_REG_READ: first_byte = {PFX_REG_READ, cmd_addr};
            default: first_byte = {PFX_REG_WRITE, cmd_addr};
        endcase
    end

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        hold_d = hold_q;
        sh_d = sh_q;
        bit_d = bit_q;
        bytes_d = bytes_q;
        hdr_d = hdr_q;
        op_d = op_q;
        sclk_d = sclk_q;
        sel_n_d = sel_n_q;
        standby_d = standby_q;
        cont_d = cont_q;
        run_d = run_q;
        rdv_d = 1'b0;
        rdd_d = rdd_q;
        ref_d = 1'b0;
        if (hold_q != '0) begin
            hold_d = hold_q - 1'b1;
        end
        unique case (st_q)
            SOCD_IDLE: begin
                if (cmd_valid && hold_q == '0) begin
                    if (!legal) begin
                        ref_d = 1'b1;
                    end else begin
                        op_d = cmd_code;
                        sh_d = first_byte;
                        bit_d = 3'h7;
                        hdr_d = 10'd1;
                        bytes_d = 10'd0;
                        if (cmd_code == CMD_REG_READ || cmd_code == CMD_REG_WRITE) begin
                            hdr_d = 10'd2;
                            bytes_d = 10'(cmd_count) + 10'd1;
                        end else if (cmd_code == CMD_SINGLE_READ) begin
                            bytes_d = 10'(DATA_BYTES);
                        end
                        sel_n_d = 1'b0;
                        cnt_d = HALF_W;
                        st_d = SOCD_SHIFT;
                        if (cmd_code == CMD_CONT_READ) begin
                            cnt_d = GAP_W;
                            st_d = SOCD_WAITRDY;
                        end else if (cmd_code == CMD_SINGLE_READ) begin
                            st_d = SOCD_WAITRDY;
                        end
                    end
                end
            end
            SOCD_WAITRDY: begin
                if (op_q == CMD_CONT_READ) begin
                    // Synchroniser lag hides a fresh edge, so demand a full quiet span;
                    // assumes one byte is far shorter than a conversion period
                    if (rdy_s_q[2] != rdy_s_q[1]) begin
                        cnt_d = GAP_W;
                    end else if (cnt_q != '0) begin
                        cnt_d = cnt_q - 1'b1;
                    end else begin
                        cnt_d = HALF_W;
                        st_d = SOCD_SHIFT;
                    end
                end else if (!rdy_s_q[2]) begin
                    // Ready low: output register already refreshed
                    st_d = SOCD_SHIFT;
                end
            end
            SOCD_SHIFT: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    cnt_d = HALF_W;
                    sclk_d = !sclk_q;
                    if (sclk_q) begin
                        // Sample on falling edge, half a bit after the device launches
                        rdd_d = {rdd_q[6:0], miso_s_q[2]};
                        sh_d = {sh_q[6:0], 1'b0};
                        if (bit_q == 3'h0) begin
                            bit_d = 3'h7;
                            st_d = SOCD_GAP;
                            cnt_d = GAP_W;
                            if (hdr_q == '0) begin
                                rdv_d = (op_q != CMD_REG_WRITE);
                                bytes_d = bytes_q - 1'b1;
                            end else begin
                                hdr_d = hdr_q - 1'b1;
                            end
                        end else begin
                            bit_d = bit_q - 1'b1;
                        end
                    end
                end
            end
            SOCD_GAP: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    st_d = SOCD_NEXT;
                end
            end
            SOCD_NEXT: begin
                cnt_d = HALF_W;
                if (hdr_q == 10'd1) begin
                    sh_d = {PFX_COUNT, 5'(bytes_q - 10'd1)};
                    st_d = SOCD_SHIFT;
                end else if (bytes_q != '0) begin
                    if (op_q == CMD_REG_WRITE) begin
                        if (wr_data_ready) begin
                            sh_d = wr_data;
                            st_d = SOCD_SHIFT;
                        end
                    end else begin
                        sh_d = 8'h00;
                        st_d = SOCD_SHIFT;
                    end
                end else begin
                    st_d = SOCD_HOLD;
                end
            end
            SOCD_HOLD: begin
                sel_n_d = 1'b1;
                st_d = SOCD_IDLE;
                hold_d = GAP_W;
                unique case (op_q)
                    CMD_STANDBY: standby_d = 1'b1;
                    CMD_WAKEUP: standby_d = 1'b0;
                    CMD_RESET: begin
                        hold_d = RST_W;
                        run_d = 1'b0;
                    end
                    CMD_START: run_d = 1'b1;
                    CMD_STOP: run_d = 1'b0;
                    CMD_CONT_READ: cont_d = 1'b1;
                    CMD_STOP_CONT: cont_d = 1'b0;
                    default: hold_d = (op_q == CMD_SINGLE_READ) ? '0 : GAP_W;
                endcase
            end
            default: st_d = SOCD_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= SOCD_IDLE;
            cnt_q <= '0;
            hold_q <= '0;
            sh_q <= 8'h00;
            bit_q <= 3'h7;
            bytes_q <= '0;
            hdr_q <= '0;
            op_q <= CMD_WAKEUP;
            sclk_q <= 1'b0;
            sel_n_q <= 1'b1;
            standby_q <= 1'b0;
            cont_q <= 1'b1;
            run_q <= 1'b0;
            rdv_q <= 1'b0;
            rdd_q <= 8'h00;
            ref_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            hold_q <= hold_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            bytes_q <= bytes_d;
            hdr_q <= hdr_d;
            op_q <= op_d;
            sclk_q <= sclk_d;
            sel_n_q <= sel_n_d;
            standby_q <= standby_d;
            cont_q <= cont_d;
            run_q <= run_d;
            rdv_q <= rdv_d;
            rdd_q <= rdd_d;
            ref_q <= ref_d;
        end
    end

    assign cmd_ready = (st_q == SOCD_IDLE) && (hold_q == '0) && clk_en;
    assign wr_data_ready = (st_q == SOCD_NEXT) && (op_q == CMD_REG_WRITE)
        && (hdr_q == '0) && (bytes_q != '0);
    assign rd_valid = rdv_q;
    assign rd_data = rdd_q;
    assign cmd_refused = ref_q;
    assign standby = standby_q;
    assign cont_read = cont_q;
    assign running = run_q;
    assign ser_clk = sclk_q;
    assign ser_sel_n = sel_n_q;
    assign ser_mosi = sh_q[7];
    assign start_pin = 1'b0;
endmodule

// ### dv/socd_host_sva.sv
/* Port checker for socd_host.
 Bound to every socd_host instance; sees its ports only. */
`timescale 1ns/10ps
module socd_host_sva
    import socd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [3:0] cmd_code,
    input wire logic [4:0] cmd_addr,
    input wire logic [4:0] cmd_count,
    input wire logic wr_data_ready,
    input wire logic [7:0] wr_data,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic cmd_refused,
    input wire logic standby,
    input wire logic cont_read,
    input wire logic running,
    input wire logic ser_clk,
    input wire logic ser_sel_n,
    input wire logic ser_mosi,
    input wire logic ser_miso,
    input wire logic start_pin,
    input wire logic result_ready_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire take = clk_en && cmd_valid && cmd_ready;
    a_start_pin_low: assert property (start_pin == 1'h0)
        else $error("start pin high");
    a_take_select: assert property (take |-> ##[1:2] (!ser_sel_n || cmd_refused))
        else $error("taken command neither sent nor refused");
    a_standby_refuse: assert property (take && standby && cmd_code != CMD_WAKEUP
        |-> ##[1:2] cmd_refused) else $error("command sent in standby");
    a_cont_refuse: assert property (take && !standby && cont_read
        && cmd_code != CMD_CONT_READ && cmd_code != CMD_STOP_CONT |-> ##[1:2] cmd_refused)
        else $error("command sent in continuous mode");
    a_clk_framed: assert property (ser_clk |-> !ser_sel_n)
        else $error("link clock outside select");
    a_busy_frame: assert property (!ser_sel_n |-> !cmd_ready)
        else $error("ready during frame");
    a_mosi_steady: assert property ($rose(ser_clk) |-> $stable(ser_mosi))
        else $error("data moved at sampling edge");
    a_read_pulse: assert property (rd_valid |=> !rd_valid)
        else $error("read strobe longer than one cycle");
endmodule
bind socd_host socd_host_sva socd_host_sva_inst (.*);

// ### dv/socd_dev_model.sv
/* Behavioural converter model on the far side of socd_host.
 Slave launching data on the rising clock; ready pulses only while converting. */
`timescale 1ns/10ps
module socd_dev_model
    import socd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic ser_clk,
    input wire logic ser_sel_n,
    input wire logic ser_mosi,
    output logic ser_miso = 1'h0,
    output logic result_ready_n = 1'h1
);
    logic [7:0] regs [32];
    logic [7:0] sh, ob, hdr;
    logic [7:0] rx_q [$];
    logic cont_q = 1'h1;
    logic sby_q = 1'h0;
    logic run_q = 1'h0;
    int bc, nb;
    int tick = 0;
    initial foreach (regs[i]) regs[i] = 8'h00;
    always @(posedge ref_clk) begin
        tick <= (tick == 399) ? 0 : tick + 1;
        result_ready_n <= !(run_q && tick >= 300);
    end
    always @(negedge ser_sel_n) begin
        bc = 0;
        nb = 0;
        ob = 8'h00;
    end
    // Released line flips so a stale bit is never read as valid
    always @(posedge ser_sel_n) ser_miso = ~ser_miso;
    always @(posedge ser_clk) if (!ser_sel_n) begin
        // Launch before counting, so the 17th edge of a register read shows the MSB
        ser_miso = ob[7 - bc];
        sh = {sh[6:0], ser_mosi};
        bc = bc + 1;
        if (bc == 8) begin
            bc = 0;
            rx_q.push_back(sh);
            if (nb == 0) hdr = sh;
            if (nb == 0 && sh == OP_WAKEUP) sby_q = 1'h0;
            else if (nb == 0 && !sby_q) begin
                case (sh)
                    OP_STANDBY: sby_q = 1'h1;
                    OP_RESET: foreach (regs[i]) regs[i] = 8'h00;
                    OP_START: run_q = 1'h1;
                    OP_STOP: run_q = 1'h0;
                    OP_CONT_READ: cont_q = 1'h1;
                    OP_STOP_CONT: cont_q = 1'h0;
                    default: ;
                endcase
            end
            if (nb >= 2 && hdr[7:5] == PFX_REG_WRITE) regs[hdr[4:0] + nb - 2] = sh;
            ob = 8'h00;
            if (nb >= 1 && hdr[7:5] == PFX_REG_READ) ob = regs[hdr[4:0] + nb - 1];
            if (hdr == OP_SINGLE_READ) ob = 8'hC0 + 8'(nb);
            nb = nb + 1;
        end
    end
endmodule

// ### dv/tb_top.sv
/* Self-checking bench for socd_host with the device model.
 Short gap and reset counts keep the run brief. */
`timescale 1ns/10ps
module tb_top;
    import socd_pkg::*;
    logic ref_clk = 1'h0, rst_b = 1'h0, clk_en = 1'h1, cmd_valid = 1'h0;
    logic [3:0] cmd_code = 4'h0;
    logic [4:0] cmd_addr = 5'h00, cmd_count = 5'h00;
    logic [7:0] wr_data = 8'h00, rd_data;
    logic cmd_ready, wr_data_ready, rd_valid, cmd_refused, standby, cont_read, running;
    logic ser_clk, ser_sel_n, ser_mosi, ser_miso, start_pin, result_ready_n, got_ref;
    int errors = 0, check_count = 0, idle_n, low_run = 0, max_low = 0, rdy_age = 0;
    logic rdy_prev = 1'h1;
    socd_host #(.DATA_BYTES(3), .GAP_CYCLES(12), .RESET_CYCLES(40)) socd_host_inst (.*);
    socd_dev_model socd_dev_model_inst (.*);
    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        low_run <= (ser_clk || ser_sel_n) ? 0 : low_run + 1;
        if (low_run > max_low) max_low <= low_run;
        rdy_age <= (result_ready_n != rdy_prev) ? 0 : rdy_age + 1;
        rdy_prev <= result_ready_n;
    end
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_idle();
        idle_n = 0;
        while (!(cmd_ready && ser_sel_n) && idle_n < 20000) begin
            step();
            idle_n++;
        end
        if (idle_n >= 20000) errors++;
    endtask
    task automatic send(logic [3:0] c, logic [4:0] a = 5'h00, logic [4:0] k = 5'h00);
        {cmd_code, cmd_addr, cmd_count, cmd_valid} = {c, a, k, 1'h1};
        socd_dev_model_inst.rx_q.delete();
        wait_idle();
        step();
        cmd_valid = 1'h0;
        got_ref = cmd_refused;
        repeat (2) begin
            step();
            got_ref |= cmd_refused;
        end
    endtask
    task automatic tx(string what, logic [7:0] exp);
        chk(what, exp, socd_dev_model_inst.rx_q.size() ? socd_dev_model_inst.rx_q.pop_front()
            : 8'hxx);
    endtask
    task automatic rd(logic [7:0] exp);
        int n = 0;
        while (!rd_valid && n < 20000) begin
            step();
            n++;
        end
        if (n >= 20000) errors++;
        chk("rd_data", exp, rd_data);
        step();
    endtask
    task automatic t_cont();
        chk("cont_read", 8'h01, {7'h00, cont_read});
        chk("start_pin", 8'h00, {7'h00, start_pin});
        send(CMD_START);
        chk("cmd_refused", 8'h01, {7'h00, got_ref});
        send(4'hF);
        chk("cmd_refused", 8'h01, {7'h00, got_ref});
        send(CMD_STOP_CONT);
        wait_idle();
        tx("stop cont byte", OP_STOP_CONT);
        chk("cont_read", 8'h00, {7'h00, cont_read});
        $display("test cont done");
    endtask
    task automatic t_sys();
        logic [3:0] c [5] = '{CMD_START, CMD_STOP, CMD_STANDBY, CMD_WAKEUP, CMD_RESET};
        logic [7:0] o [5] = '{OP_START, OP_STOP, OP_STANDBY, OP_WAKEUP, OP_RESET};
        for (int i = 0; i < 5; i++) begin
            send(c[i]);
            wait_idle();
            tx("system byte", o[i]);
            if (i < 3) chk("mode", 8'(i == 2 ? 4 : 1 - i), {5'h00, standby, 1'h0, running});
            if (i == 2) send(CMD_START);
            if (i == 2) chk("cmd_refused", 8'h01, {7'h00, got_ref});
        end
        chk("reset busy", 8'h01, {7'h00, idle_n >= 130});
        if (cont_read) send(CMD_STOP_CONT);
        wait_idle();
        $display("test system done");
    endtask
    task automatic t_reg();
        int n;
        max_low = 0;
        wr_data = 8'h3C;
        send(CMD_REG_WRITE, 5'h05, 5'h01);
        for (int k = 0; k < 2; k++) begin
            for (n = 0; !wr_data_ready && n < 5000; n++) step();
            if (n >= 5000) errors++;
            step();
            wr_data = 8'hA7;
        end
        wait_idle();
        tx("write header", {PFX_REG_WRITE, 5'h05});
        tx("write count", {PFX_COUNT, 5'h01});
        tx("write data", 8'h3C);
        tx("write data", 8'hA7);
        chk("byte gap", 8'h01, {7'h00, max_low >= 12});
        send(CMD_REG_READ, 5'h05, 5'h01);
        rd(8'h3C);
        rd(8'hA7);
        wait_idle();
        tx("read header", {PFX_REG_READ, 5'h05});
        $display("test register done");
    endtask
    task automatic t_single();
        send(CMD_START);
        wait_idle();
        send(CMD_SINGLE_READ);
        for (int k = 0; k < 3; k++) rd(8'hC0 + 8'(k));
        wait_idle();
        tx("single read byte", OP_SINGLE_READ);
        $display("test single read done");
    endtask
    task automatic t_cont_read();
        logic [2:0] snap;
        int n;
        wait_idle();
        for (n = 0; !result_ready_n && n < 1000; n++) step();
        for (n = 0; result_ready_n && n < 1000; n++) step();
        if (n >= 1000) errors++;
        send(CMD_CONT_READ);
        for (n = 0; !ser_clk && n < 1000; n++) step();
        chk("ready keep-out", 8'h01, {7'h00, rdy_age >= 12});
        clk_en = 1'h0;
        snap = {ser_clk, ser_sel_n, ser_mosi};
        repeat (20) step();
        chk("frozen link", {5'h00, snap}, {5'h00, ser_clk, ser_sel_n, ser_mosi});
        chk("frozen ready", 8'h00, {7'h00, cmd_ready});
        clk_en = 1'h1;
        wait_idle();
        tx("cont read byte", OP_CONT_READ);
        chk("cont_read", 8'h01, {7'h00, cont_read});
        send(CMD_STOP_CONT);
        wait_idle();
        tx("stop cont byte", OP_STOP_CONT);
        chk("cont_read", 8'h00, {7'h00, cont_read});
        $display("test cont read done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 rst_b = 1'h1;
        step();
        t_cont();
        t_sys();
        t_reg();
        t_single();
        t_cont_read();
        final_report();
    end
    // Whole run needs a few thousand cycles; allow far more
    initial begin
        #400000;
        errors++;
        final_report();
    end
endmodule
